// ===== design/wake_on_lan_receive_config.sv
// Wake-on-LAN receive configuration, status and wake output with a Wishbone slave
//
// Summary of operation
// - In pulse mode each wake pulse lasts 8, 16, 32 or 64 reference cycles for length codes 00 to 11.
// - The output level select bit picks level mode when 1 and pulse mode when 0.
// - Writing 1 to the output clear bit drops a level-mode wake output, the bit reads back 0 and does nothing in pulse mode.
// - The enhanced receive enable turns on wake detection, CRC checking and receive timestamp indication.
// - With the password enable set a magic packet counts only when its password matches the stored one.
// - The unicast wake enable lets a valid unicast packet raise a wake.
// - The broadcast wake enable lets a valid broadcast packet raise a wake and resets to 1.
// - The pattern wake enable lets a pattern match raise a wake.
// - The magic wake enable lets a valid magic packet raise a wake.
// - Each received wake event type sets its own status flag that latches high and clears when read.
// - The 48-bit password is loaded as three 16-bit words, lowest bits in the first.

`include "wol_map.svh"

module wake_on_lan_receive_config (
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  // Wishbone classic slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [11:0] wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // Packet parser events (same clock)
  input  wire logic        magic_det_i,
  input  wire logic [47:0] magic_password_i,
  input  wire logic        pattern_det_i,
  input  wire logic        bcast_det_i,
  input  wire logic        ucast_det_i,
  // Receive path feature enables
  output logic             wake_detect_en_o,
  output logic             crc_check_en_o,
  output logic             rx_timestamp_en_o,
  // Wake and interrupt
  output logic             wake_o,
  output logic             irq_o
);

  // ========================================================================
  // Constants
  typedef wol_pkg::pulse_cnt_t pulse_cnt_t;

  // Reference lengths rounded up to whole bus clocks, never shorter
  localparam pulse_cnt_t PULSE_CYC0 = 7'(`WOL_PULSE_CYC(`WOL_PULSE_LEN0));
  localparam pulse_cnt_t PULSE_CYC1 = 7'(`WOL_PULSE_CYC(`WOL_PULSE_LEN1));
  localparam pulse_cnt_t PULSE_CYC2 = 7'(`WOL_PULSE_CYC(`WOL_PULSE_LEN2));
  localparam pulse_cnt_t PULSE_CYC3 = 7'(`WOL_PULSE_CYC(`WOL_PULSE_LEN3));

  // ========================================================================
  // Declarations
  logic [15:0]          cfg_r;
  logic [15:0]          status_r;
  logic [15:0]          irq_status_r;
  logic [15:0]          irq_mask_r;
  logic [15:0]          password_r [3];
  logic                 ack_r;
  logic [31:0]          rdata_r;
  logic                 req;
  logic                 wr_fire;
  logic                 rd_fire;
  logic [9:0]           idx;
  logic [15:0]          wmask;
  logic [15:0]          rd_mux;
  logic [15:0]          events;
  logic [47:0]          password;
  logic                 magic_ok;
  logic                 wake_event;
  logic                 clear_req;
  logic                 level_mode;
  pulse_cnt_t           pulse_len;
  pulse_cnt_t           pulse_cnt_r;
  wol_pkg::wake_state_t state_r;
  wol_pkg::wake_state_t state_nxt;
  pulse_cnt_t           pulse_cnt_nxt;
  logic [15:0]          cfg_nxt;
  logic [15:0]          status_nxt;
  logic [15:0]          status_clr;
  logic [15:0]          irq_status_nxt;
  logic [15:0]          irq_clr;
  logic [15:0]          irq_mask_nxt;
  logic                 ack_nxt;
  logic [31:0]          rdata_nxt;
  logic                 hit_cfg;
  logic                 hit_sts;
  logic [2:0]           hit_pw;
  logic                 hit_irq_sts;
  logic                 hit_irq_mask;
  logic                 pw_match;
  logic [3:0]           ev_type;
  logic [3:0]           wake_en;
  logic [3:0]           wake_hits;

  // ========================================================================
  // Bus decode
  // Writes and clear-on-read act at the edge where the master samples ack.
  assign req     = wb_cyc_i & wb_stb_i;
  assign idx     = wb_adr_i[11:2];
  assign wr_fire = req & ack_r & wb_we_i;
  assign rd_fire = req & ack_r & ~wb_we_i;
  assign wmask   = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  assign ack_nxt = req & ~ack_r;

  // One hit per mapped register; unmapped indices are still acked
  assign hit_cfg      = idx == `WOL_IDX_CONFIG;
  assign hit_sts      = idx == `WOL_IDX_STATUS;
  assign hit_pw[0]    = idx == `WOL_IDX_PASSWORD0;
  assign hit_pw[1]    = idx == `WOL_IDX_PASSWORD1;
  assign hit_pw[2]    = idx == `WOL_IDX_PASSWORD2;
  assign hit_irq_sts  = idx == `WOL_IDX_IRQ_STATUS;
  assign hit_irq_mask = idx == `WOL_IDX_IRQ_MASK;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= ack_nxt;
    end
  end

  always_comb begin
    rd_mux = 16'h0000;
    case (idx)
      `WOL_IDX_CONFIG:     rd_mux = cfg_r & `WOL_CFG_RW_MASK;
      `WOL_IDX_STATUS:     rd_mux = status_r;
      `WOL_IDX_PASSWORD0:  rd_mux = password_r[0];
      `WOL_IDX_PASSWORD1:  rd_mux = password_r[1];
      `WOL_IDX_PASSWORD2:  rd_mux = password_r[2];
      `WOL_IDX_IRQ_STATUS: rd_mux = irq_status_r;
      `WOL_IDX_IRQ_MASK:   rd_mux = irq_mask_r;
      default:             rd_mux = 16'h0000;
    endcase
  end

  // Read data is captured as ack rises and held through the sampling edge
  always_comb begin
    rdata_nxt = rdata_r;
    if (ack_nxt) begin
      rdata_nxt = {16'h0000, rd_mux};
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_r <= 32'h0000_0000;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  assign wb_dat_o = rdata_r;
  assign wb_ack_o = ack_r;

  // ========================================================================
  // Configuration register
  // Reserved and self-clearing bits are never stored
  always_comb begin
    cfg_nxt = cfg_r;
    if (wr_fire && hit_cfg) begin
      cfg_nxt = (cfg_r & ~(wmask & `WOL_CFG_RW_MASK)) |
                (wb_dat_i[15:0] & wmask & `WOL_CFG_RW_MASK);
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cfg_r <= `WOL_CFG_RESET;
    end else begin
      cfg_r <= cfg_nxt;
    end
  end

  // Self-clearing: acts only in the write cycle, never stored
  assign clear_req = wr_fire && idx == `WOL_IDX_CONFIG && wb_sel_i[1] &&
                     wb_dat_i[`WOL_CFG_CLEAR];

  assign level_mode        = cfg_r[`WOL_CFG_LEVEL_MODE];
  assign wake_detect_en_o  = cfg_r[`WOL_CFG_ENHANCED];
  assign crc_check_en_o    = cfg_r[`WOL_CFG_ENHANCED];
  assign rx_timestamp_en_o = cfg_r[`WOL_CFG_ENHANCED];

  // ========================================================================
  // Password words
  for (genvar w = 0; w < 3; w++) begin : g_pw
    always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
        password_r[w] <= 16'h0000;
      end else if (wr_fire && hit_pw[w]) begin
        password_r[w] <= (password_r[w] & ~wmask) | (wb_dat_i[15:0] & wmask);
      end
    end
  end

  assign password = {password_r[2], password_r[1], password_r[0]};

  // Whole 48-bit compare; a partial match never counts
  assign pw_match = magic_password_i == password;

  // ========================================================================
  // Event qualification
  // Nothing is detected while enhanced receive features are off.
  always_comb begin
    magic_ok = magic_det_i & (~cfg_r[`WOL_CFG_PW_EN] | pw_match);
    events   = 16'h0000;
    if (cfg_r[`WOL_CFG_ENHANCED]) begin
      events[`WOL_STS_MAGIC]   = magic_ok;
      events[`WOL_STS_PATTERN] = pattern_det_i;
      events[`WOL_STS_BCAST]   = bcast_det_i;
      events[`WOL_STS_UCAST]   = ucast_det_i;
      events[`WOL_STS_PW_FAIL] = magic_det_i & ~magic_ok;
    end
  end

  // One enable per wake source; status flags ignore these enables
  assign ev_type[0] = events[`WOL_STS_MAGIC];
  assign ev_type[1] = events[`WOL_STS_PATTERN];
  assign ev_type[2] = events[`WOL_STS_BCAST];
  assign ev_type[3] = events[`WOL_STS_UCAST];
  assign wake_en[0] = cfg_r[`WOL_CFG_MAGIC_EN];
  assign wake_en[1] = cfg_r[`WOL_CFG_PATTERN_EN];
  assign wake_en[2] = cfg_r[`WOL_CFG_BCAST_EN];
  assign wake_en[3] = cfg_r[`WOL_CFG_UCAST_EN];
  assign wake_hits  = ev_type & wake_en;
  assign wake_event = |wake_hits;

  // ========================================================================
  // Receive status, latched high, cleared on read
  // Only bits returned by the read are cleared, so a new event wins.
  assign status_clr = (rd_fire && hit_sts) ? rdata_r[15:0] : 16'h0000;
  assign status_nxt = (status_r & ~status_clr) | events;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      status_r <= 16'h0000;
    end else begin
      status_r <= status_nxt;
    end
  end

  // ========================================================================
  // Interrupt status (write one to clear) and mask
  // An event in the clearing cycle keeps its bit set
  assign irq_clr        = (wr_fire && hit_irq_sts) ? (wb_dat_i[15:0] & wmask) : 16'h0000;
  assign irq_status_nxt = (irq_status_r & ~irq_clr) | events;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      irq_status_r <= 16'h0000;
    end else begin
      irq_status_r <= irq_status_nxt;
    end
  end

  always_comb begin
    irq_mask_nxt = irq_mask_r;
    if (wr_fire && hit_irq_mask) begin
      irq_mask_nxt = (irq_mask_r & ~(wmask & `WOL_STS_MASK)) |
                     (wb_dat_i[15:0] & wmask & `WOL_STS_MASK);
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      irq_mask_r <= `WOL_IRQ_MASK_RESET;
    end else begin
      irq_mask_r <= irq_mask_nxt;
    end
  end

  assign irq_o = |(irq_status_r & irq_mask_r);

  // ========================================================================
  // Wake output
  always_comb begin
    case (cfg_r[`WOL_CFG_LEN_HI:`WOL_CFG_LEN_LO])
      2'b00:   pulse_len = PULSE_CYC0;
      2'b01:   pulse_len = PULSE_CYC1;
      2'b10:   pulse_len = PULSE_CYC2;
      2'b11:   pulse_len = PULSE_CYC3;
      default: pulse_len = PULSE_CYC0;
    endcase
  end

  // A new event restarts a running pulse; in level mode a same-cycle
  // event beats the clear. Leaving level mode drops a held level, since
  // the clear has no effect in pulse mode and it could never be released.
  always_comb begin
    state_nxt     = state_r;
    pulse_cnt_nxt = pulse_cnt_r;
    case (state_r)
      wol_pkg::WAKE_IDLE: begin
        if (wake_event && level_mode) begin
          state_nxt = wol_pkg::WAKE_LEVEL;
        end else if (wake_event) begin
          state_nxt     = wol_pkg::WAKE_PULSE;
          pulse_cnt_nxt = pulse_len - 7'h01;
        end
      end
      wol_pkg::WAKE_PULSE: begin
        if (wake_event && level_mode) begin
          state_nxt = wol_pkg::WAKE_LEVEL;
        end else if (wake_event) begin
          pulse_cnt_nxt = pulse_len - 7'h01;
        end else if (pulse_cnt_r == 7'h00) begin
          state_nxt = wol_pkg::WAKE_IDLE;
        end else begin
          pulse_cnt_nxt = pulse_cnt_r - 7'h01;
        end
      end
      wol_pkg::WAKE_LEVEL: begin
        if (!level_mode) begin
          state_nxt = wol_pkg::WAKE_IDLE;
        end else if (clear_req && !wake_event) begin
          state_nxt = wol_pkg::WAKE_IDLE;
        end
      end
      default: begin
        state_nxt     = wol_pkg::WAKE_IDLE;
        pulse_cnt_nxt = 7'h00;
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_r     <= wol_pkg::WAKE_IDLE;
      pulse_cnt_r <= 7'h00;
    end else begin
      state_r     <= state_nxt;
      pulse_cnt_r <= pulse_cnt_nxt;
    end
  end

  assign wake_o = (state_r == wol_pkg::WAKE_PULSE) | (state_r == wol_pkg::WAKE_LEVEL);

endmodule : wake_on_lan_receive_config

// ===== design/wol_map.svh
// Register indices, field positions, reset values and timing counts of the wake-on-LAN block
`ifndef WOL_MAP_SVH
`define WOL_MAP_SVH

// ==========================================================================
// Register indices (byte address = 4 * index)
`define WOL_IDX_CONFIG      10'h134
`define WOL_IDX_STATUS      10'h135
`define WOL_IDX_PASSWORD0   10'h139
`define WOL_IDX_PASSWORD1   10'h13a
`define WOL_IDX_PASSWORD2   10'h13b
`define WOL_IDX_IRQ_STATUS  10'h180
`define WOL_IDX_IRQ_MASK    10'h181

// ==========================================================================
// Configuration fields
`define WOL_CFG_MAGIC_EN    0
`define WOL_CFG_PATTERN_EN  1
`define WOL_CFG_BCAST_EN    2
`define WOL_CFG_UCAST_EN    4
`define WOL_CFG_PW_EN       5
`define WOL_CFG_ENHANCED    7
`define WOL_CFG_LEVEL_MODE  8
`define WOL_CFG_LEN_LO      9
`define WOL_CFG_LEN_HI      10
`define WOL_CFG_CLEAR       11
`define WOL_CFG_RW_MASK     16'h07b7
`define WOL_CFG_RESET       16'h0004

// ==========================================================================
// Status fields (same layout in interrupt status and mask)
`define WOL_STS_MAGIC       0
`define WOL_STS_PATTERN     1
`define WOL_STS_BCAST       2
`define WOL_STS_UCAST       4
`define WOL_STS_PW_FAIL     5
`define WOL_STS_MASK        16'h0037
`define WOL_IRQ_MASK_RESET  16'h0000

// ==========================================================================
// Pulse timing: lengths in 125 MHz cycles, converted to 200 MHz cycles
`define WOL_REF_PERIOD_PS   8000
`define WOL_CLK_PERIOD_PS   5000
`define WOL_PULSE_CYC(n)    (((n) * `WOL_REF_PERIOD_PS + `WOL_CLK_PERIOD_PS - 1) / `WOL_CLK_PERIOD_PS)
`define WOL_PULSE_LEN0      8
`define WOL_PULSE_LEN1      16
`define WOL_PULSE_LEN2      32
`define WOL_PULSE_LEN3      64

`endif

// ===== design/wol_pkg.sv
// Types shared by the wake-on-LAN configuration block
package wol_pkg;

  // ========================================================================
  // Wake output state
  typedef enum logic [2:0] {
    WAKE_IDLE  = 3'b001,
    WAKE_PULSE = 3'b010,
    WAKE_LEVEL = 3'b100
  } wake_state_t;

  typedef logic [6:0] pulse_cnt_t;

endpackage : wol_pkg

// ===== tb/wake_host_model.sv
// Host-side observer that measures each pulse on the wake line
module wake_host_model (
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  input  wire logic       wake_i,
  output logic      [7:0] len_o,
  output logic      [7:0] pulses_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] cnt_r;
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_r    <= 8'h00;
      len_o    <= 8'h00;
      pulses_o <= 8'h00;
    end else if (wake_i) begin
      cnt_r <= cnt_r + 8'h01;
    end else if (cnt_r != 8'h00) begin
      // Width is in bench cycles; a held level counts only once it falls
      len_o    <= cnt_r;
      pulses_o <= pulses_o + 8'h01;
      cnt_r    <= 8'h00;
    end
  end
endmodule : wake_host_model

// ===== tb/wake_on_lan_receive_config_tb.sv
// Self-checking bench for the wake-on-LAN configuration block
module wake_on_lan_receive_config_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [11:0] cfg_a = 12'h4d0;
  localparam logic [11:0] sts_a = 12'h4d4;
  logic        clk_i = 1'b0, rst_n_i = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [11:0] wb_adr_i = 12'h000;
  logic [3:0]  wb_sel_i = 4'h3;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd;
  logic        wb_ack_o, wake_detect_en_o, crc_check_en_o, rx_timestamp_en_o, wake_o, irq_o;
  logic        magic_det_i = 1'b0, pattern_det_i = 1'b0, bcast_det_i = 1'b0, ucast_det_i = 1'b0;
  logic [47:0] magic_password_i = 48'h0;
  logic [7:0]  len, pulses, p0;
  int          err_total = 0, cmp_count = 0, cyc_n = 0;
  int          pos[4] = '{0, 1, 2, 4};

  always #2.5 clk_i = ~clk_i;
  wake_on_lan_receive_config wake_on_lan_receive_config_inst (.*);
  wake_host_model wake_host_model_inst (.clk_i(clk_i), .rst_n_i(rst_n_i), .wake_i(wake_o), .len_o(len),
    .pulses_o(pulses));

  task automatic final_report;
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : final_report

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // ==========================================================================
  // Wishbone classic cycle; read data lands in rd
  task automatic wb(input logic we, input logic [11:0] a, input logic [15:0] d);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= a;
    wb_dat_i <= {16'h0000, d};
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask : wb

  task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
    wb(1'b0, a, 16'h0000);
    chk(rd, exp);
  endtask : rdchk

  // One-cycle event, then long enough for the longest pulse to end
  task automatic fire(input int i, input logic [47:0] pw);
    @(posedge clk_i);
    {ucast_det_i, bcast_det_i, pattern_det_i, magic_det_i} <= 4'(1 << i);
    magic_password_i <= pw;
    @(posedge clk_i);
    {ucast_det_i, bcast_det_i, pattern_det_i, magic_det_i} <= 4'h0;
    repeat (110) @(posedge clk_i);
  endtask : fire

  always @(posedge clk_i) begin
    cyc_n <= cyc_n + 1;
    if (cyc_n == 8000) begin
      err_total++;
      final_report();
    end
  end

  initial begin
    repeat (12) @(posedge clk_i);
    rst_n_i <= 1'b1;
    rdchk(cfg_a, 32'h0004);
    wb(1'b1, cfg_a, 16'hffff);
    rdchk(cfg_a, 32'h07b7);
    chk(32'({wake_detect_en_o, crc_check_en_o, rx_timestamp_en_o}), 32'h7);
    rdchk(12'h7fc, 32'h0);
    for (int c = 0; c < 4; c++) begin
      wb(1'b1, cfg_a, 16'(16'h0084 | (c << 9)));
      fire(2, 48'h0);
      chk(32'(len), ((8 << c) * 8 + 4) / 5);
    end
    rdchk(sts_a, 32'h4);
    rdchk(sts_a, 32'h0);
    for (int i = 0; i < 4; i++) begin
      for (int on = 0; on < 2; on++) begin
        p0 = pulses;
        wb(1'b1, cfg_a, 16'h0080 | (on != 0 ? 16'(1 << pos[i]) : 16'h0017 & ~16'(1 << pos[i])));
        fire(i, 48'h0);
        chk(32'(pulses - p0), on);
        rdchk(sts_a, 32'(1 << pos[i]));
      end
    end
    wb(1'b1, 12'h4e4, 16'h1111);
    wb(1'b1, 12'h4e8, 16'h2222);
    wb(1'b1, 12'h4ec, 16'h3333);
    wb(1'b1, cfg_a, 16'h00a1);
    p0 = pulses;
    fire(0, 48'h1111_2222_3333);
    rdchk(sts_a, 32'h20);
    fire(0, 48'h3333_2222_1111);
    rdchk(sts_a, 32'h1);
    chk(32'(pulses - p0), 32'h1);
    wb(1'b1, cfg_a, 16'h0081);
    fire(0, 48'h0);
    rdchk(sts_a, 32'h1);
    wb(1'b1, cfg_a, 16'h0017);
    p0 = pulses;
    fire(2, 48'h0);
    chk(32'(pulses - p0), 32'h0);
    rdchk(sts_a, 32'h0);
    chk(32'({wake_detect_en_o, crc_check_en_o, rx_timestamp_en_o}), 32'h0);
    wb(1'b1, 12'h600, 16'h0037);
    wb(1'b1, 12'h604, 16'h0004);
    wb(1'b1, cfg_a, 16'h0184);
    fire(2, 48'h0);
    chk(32'({wake_o, irq_o}), 32'h3);
    wb(1'b1, 12'h604, 16'h0000);
    @(posedge clk_i);
    chk(32'(irq_o), 32'h0);
    wb(1'b1, 12'h604, 16'h0004);
    @(posedge clk_i);
    chk(32'(irq_o), 32'h1);
    wb(1'b1, 12'h600, 16'h0004);
    @(posedge clk_i);
    chk(32'(irq_o), 32'h0);
    wb(1'b1, cfg_a, 16'h0984);
    @(posedge clk_i);
    chk(32'(wake_o), 32'h0);
    rdchk(cfg_a, 32'h0184);
    final_report();
  end
endmodule : wake_on_lan_receive_config_tb

// ===== tb/wol_monitor.sv
// Port-level checker for the wake-on-LAN configuration block
`include "wol_map.svh"
module wol_monitor (
  input wire logic        clk_i,
  input wire logic        rst_n_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [11:0] wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic        magic_det_i,
  input wire logic [47:0] magic_password_i,
  input wire logic        pattern_det_i,
  input wire logic        bcast_det_i,
  input wire logic        ucast_det_i,
  input wire logic        wake_detect_en_o,
  input wire logic        crc_check_en_o,
  input wire logic        rx_timestamp_en_o,
  input wire logic        wake_o,
  input wire logic        irq_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  logic lvl_r;
  logic cfg_hit;
  logic cfg_wr;
  logic ev_any;
  assign cfg_hit = wb_ack_o && wb_adr_i[11:2] == `WOL_IDX_CONFIG;
  assign cfg_wr  = cfg_hit && wb_we_i && wb_sel_i[1];
  assign ev_any  = magic_det_i || pattern_det_i || bcast_det_i || ucast_det_i;
  // ==========================================================================
  // Shadow of the output mode, so level-only checks know when they apply
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      lvl_r <= 1'b0;
    end else if (cfg_wr) begin
      lvl_r <= wb_dat_i[`WOL_CFG_LEVEL_MODE];
    end
  end
  // ==========================================================================
  // Properties
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held over one cycle");
  a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("ack late");
  a_upper_zero: assert property (wb_ack_o |-> wb_dat_o[31:16] == 16'h0000) else $error("upper data set");
  a_enable_follows: assert property (cfg_hit && wb_we_i && wb_sel_i[0] |=>
    wake_detect_en_o == $past(wb_dat_i[7]) && crc_check_en_o == wake_detect_en_o &&
    rx_timestamp_en_o == wake_detect_en_o) else $error("feature enables wrong");
  a_wake_cause: assert property ($rose(wake_o) |-> $past(ev_any && wake_detect_en_o))
    else $error("wake without enabled event");
  a_cfg_reserved: assert property (cfg_hit && !wb_we_i |-> (wb_dat_o & 32'hfffff848) == 32'h0)
    else $error("reserved config bits set");
  a_level_clear: assert property (cfg_wr && wb_dat_i[`WOL_CFG_CLEAR] && lvl_r &&
    wb_dat_i[`WOL_CFG_LEVEL_MODE] && !ev_any |=> !wake_o) else $error("level wake not cleared");
  a_level_hold: assert property (wake_o && lvl_r && !cfg_wr |=> wake_o)
    else $error("level wake dropped");
endmodule : wol_monitor

bind wake_on_lan_receive_config wol_monitor wol_monitor_inst (.*);
